// ==== core/slec_pkg.sv ====
// Package for the lane error status bank: register map, field layout, types
package slec_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_LINKS = 2;
	localparam int NUM_LANES = 8;
	localparam int CNT_W     = 8;
	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 32;
	localparam int IDX_W     = 12;
	localparam int PAGE_W    = 1;
	localparam int IRQ_W     = 3;
	localparam int NUM_CNT   = NUM_LINKS * NUM_LANES * 2;

	// ------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 12'h300;
	localparam logic [IDX_W-1:0] IDX_DESKEW    = 12'h46c;
	localparam logic [IDX_W-1:0] IDX_DISP      = 12'h46d;
	localparam logic [IDX_W-1:0] IDX_CODE      = 12'h46e;
	localparam logic [IDX_W-1:0] IDX_THRESH    = 12'h4f0;
	localparam logic [IDX_W-1:0] IDX_CTRL      = 12'h4f1;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 12'h4f2;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 12'h4f3;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0]     THRESH_RST   = 8'hff;
	localparam logic [NUM_LANES-1:0] LANE_RST     = 8'h00;
	localparam logic [CNT_W-1:0]     CNT_RST      = 8'h00;
	localparam logic [CNT_W-1:0]     CNT_MAX      = 8'hff;
	localparam logic [CNT_W-1:0]     CNT_ONE      = 8'h01;
	localparam logic [PAGE_W-1:0]    PAGE_RST     = 1'h0;
	localparam logic [IRQ_W-1:0]     IRQ_RST      = 3'h0;
	localparam int                   CTRL_CLR_BIT = 0;
	localparam int                   IRQ_DISP_BIT = 0;
	localparam int                   IRQ_CODE_BIT = 1;
	localparam int                   IRQ_DSK_BIT  = 2;
	localparam logic [1:0]           RESP_OKAY    = 2'h0;
	localparam logic [1:0]           RESP_SLVERR  = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NUM_LANES-1:0] deskew_ok;
		logic [NUM_LANES-1:0] disp_err;
		logic [NUM_LANES-1:0] code_err;
	} slec_lane_evt_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} slec_wr_state_t;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : byte_addr

endpackage : slec_pkg

// ==== core/slec_err_counters.sv ====
// Saturating per-lane error counters with threshold flags
`timescale 1ns/1ps
module slec_err_counters
	import slec_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	input  wire logic               clr_i,
	input  wire logic [CNT_W-1:0]   thresh_i,
	input  wire logic [NUM_CNT-1:0] err_i,
	output logic      [NUM_CNT-1:0] flag_o
);

	logic [CNT_W-1:0] cnt_r [NUM_CNT];
	logic [NUM_CNT-1:0] flag_r;

	assign flag_o = flag_r;

	// ------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------
	// Saturate rather than wrap so a flag never drops on overflow
	for (genvar i = 0; i < NUM_CNT; i++)
	begin : g_cnt
		wire logic [CNT_W-1:0] cnt_nxt = (cnt_r[i] == CNT_MAX) ? CNT_MAX : cnt_r[i] + CNT_ONE;
		wire logic [CNT_W-1:0] base    = clr_i ? CNT_RST : cnt_r[i];

		always_ff @(posedge clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
			begin
				cnt_r[i]  <= CNT_RST;
				flag_r[i] <= 1'b0;
			end
			else
			begin
				cnt_r[i]  <= err_i[i] ? (clr_i ? CNT_ONE : cnt_nxt) : base;
				flag_r[i] <= (cnt_r[i] >= thresh_i);
			end
		end
	end

endmodule : slec_err_counters

// ==== core/slec_status_bank.sv ====
// Top of the lane error status bank with its AXI4-Lite register slave
`timescale 1ns/1ps
module slec_status_bank
	import slec_pkg::*;
(
	input  wire logic                           SYS_CLK_I,
	input  wire logic                           RESETN_I,
	input  wire slec_lane_evt_t [NUM_LINKS-1:0] LANE_EVT_I,
	input  wire logic [ADDR_W-1:0]              S_AXI_AWADDR_I,
	input  wire logic                           S_AXI_AWVALID_I,
	output logic                                S_AXI_AWREADY_O,
	input  wire logic [DATA_W-1:0]              S_AXI_WDATA_I,
	input  wire logic [3:0]                     S_AXI_WSTRB_I,
	input  wire logic                           S_AXI_WVALID_I,
	output logic                                S_AXI_WREADY_O,
	output logic [1:0]                          S_AXI_BRESP_O,
	output logic                                S_AXI_BVALID_O,
	input  wire logic                           S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0]              S_AXI_ARADDR_I,
	input  wire logic                           S_AXI_ARVALID_I,
	output logic                                S_AXI_ARREADY_O,
	output logic [DATA_W-1:0]                   S_AXI_RDATA_O,
	output logic [1:0]                          S_AXI_RRESP_O,
	output logic                                S_AXI_RVALID_O,
	input  wire logic                           S_AXI_RREADY_I,
	output logic                                IRQ_O
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	slec_wr_state_t                 wr_state_r;
	logic                           awready_r;
	logic                           wready_r;
	logic                           bvalid_r;
	logic [1:0]                     bresp_r;
	logic                           arready_r;
	logic                           rvalid_r;
	logic [1:0]                     rresp_r;
	logic [DATA_W-1:0]              rdata_r;
	logic                           aw_got_r;
	logic                           w_got_r;
	logic [ADDR_W-1:0]              awaddr_r;
	logic [DATA_W-1:0]              wdata_r;
	logic [3:0]                     wstrb_r;
	logic [PAGE_W-1:0]              page_r;
	logic [CNT_W-1:0]               thresh_r;
	logic                           cnt_clr_r;
	logic [IRQ_W-1:0]               irq_stat_r;
	logic [IRQ_W-1:0]               irq_stat_nxt;
	logic [IRQ_W-1:0]               irq_mask_r;
	logic                           irq_r;
	logic [NUM_LANES-1:0]           deskew_r [NUM_LINKS];
	logic [NUM_LINKS*NUM_LANES-1:0] disp_prev_r;
	logic [NUM_LINKS*NUM_LANES-1:0] code_prev_r;
	logic [NUM_LINKS*NUM_LANES-1:0] dsk_prev_r;
	logic [NUM_CNT-1:0]             err_vec;
	logic [NUM_CNT-1:0]             flag_vec;
	logic [NUM_LINKS*NUM_LANES-1:0] disp_all;
	logic [NUM_LINKS*NUM_LANES-1:0] code_all;
	logic [NUM_LINKS*NUM_LANES-1:0] dsk_all;

	// ------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------
	assign S_AXI_AWREADY_O = awready_r;
	assign S_AXI_WREADY_O  = wready_r;
	assign S_AXI_BVALID_O  = bvalid_r;
	assign S_AXI_BRESP_O   = bresp_r;
	assign S_AXI_ARREADY_O = arready_r;
	assign S_AXI_RVALID_O  = rvalid_r;
	assign S_AXI_RRESP_O   = rresp_r;
	assign S_AXI_RDATA_O   = rdata_r;
	assign IRQ_O           = irq_r;

	// ------------------------------------------------------------
	// Per-lane counters
	// ------------------------------------------------------------
	// Counter slots: disparity of all links first, then code table
	for (genvar k = 0; k < NUM_LINKS; k++)
	begin : g_link
		assign err_vec[k*NUM_LANES +: NUM_LANES]                       = LANE_EVT_I[k].disp_err;
		assign err_vec[(NUM_LINKS+k)*NUM_LANES +: NUM_LANES]           = LANE_EVT_I[k].code_err;
		assign disp_all[k*NUM_LANES +: NUM_LANES]                      = flag_vec[k*NUM_LANES +: NUM_LANES];
		assign code_all[k*NUM_LANES +: NUM_LANES]                      = flag_vec[(NUM_LINKS+k)*NUM_LANES +: NUM_LANES];
		assign dsk_all[k*NUM_LANES +: NUM_LANES]                       = deskew_r[k];

		always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
		begin
			if (!RESETN_I)
				deskew_r[k] <= LANE_RST;
			else
				deskew_r[k] <= LANE_EVT_I[k].deskew_ok;
		end
	end

	slec_err_counters u_counters (
		.clk_i    (SYS_CLK_I),
		.rstn_i   (RESETN_I),
		.clr_i    (cnt_clr_r),
		.thresh_i (thresh_r),
		.err_i    (err_vec),
		.flag_o   (flag_vec)
	);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// One link's lanes out of a vector that holds all links side by side
	function automatic logic [NUM_LANES-1:0] page_sel(input logic [NUM_LINKS*NUM_LANES-1:0] vec,
	                                                  input logic [PAGE_W-1:0]              page);
		return vec[page*NUM_LANES +: NUM_LANES];
	endfunction : page_sel

	// ------------------------------------------------------------
	// Paged status view
	// ------------------------------------------------------------
	wire logic [NUM_LANES-1:0] page_deskew = page_sel(dsk_all, page_r);
	wire logic [NUM_LANES-1:0] page_disp   = page_sel(disp_all, page_r);
	wire logic [NUM_LANES-1:0] page_code   = page_sel(code_all, page_r);

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	wire logic rd_page   = (S_AXI_ARADDR_I == byte_addr(IDX_LINK_PAGE));
	wire logic rd_deskew = (S_AXI_ARADDR_I == byte_addr(IDX_DESKEW));
	wire logic rd_disp   = (S_AXI_ARADDR_I == byte_addr(IDX_DISP));
	wire logic rd_code   = (S_AXI_ARADDR_I == byte_addr(IDX_CODE));
	wire logic rd_thresh = (S_AXI_ARADDR_I == byte_addr(IDX_THRESH));
	wire logic rd_ctrl   = (S_AXI_ARADDR_I == byte_addr(IDX_CTRL));
	wire logic rd_istat  = (S_AXI_ARADDR_I == byte_addr(IDX_IRQ_STAT));
	wire logic rd_imask  = (S_AXI_ARADDR_I == byte_addr(IDX_IRQ_MASK));
	wire logic rd_hit    = rd_page | rd_deskew | rd_disp | rd_code | rd_thresh | rd_ctrl | rd_istat | rd_imask;

	// Lane n lands on bit n, lane 7 on the top bit of the low byte
	wire logic [DATA_W-1:0] rd_mux =
		rd_page   ? {{(DATA_W-PAGE_W){1'b0}}, page_r}         :
		rd_deskew ? {{(DATA_W-NUM_LANES){1'b0}}, page_deskew} :
		rd_disp   ? {{(DATA_W-NUM_LANES){1'b0}}, page_disp}   :
		rd_code   ? {{(DATA_W-NUM_LANES){1'b0}}, page_code}   :
		rd_thresh ? {{(DATA_W-CNT_W){1'b0}}, thresh_r}        :
		rd_ctrl   ? {DATA_W{1'b0}}                            : // Clear bit is a strobe, reads zero
		rd_istat  ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r}      :
		rd_imask  ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r}      :
		{DATA_W{1'b0}};

	wire logic ar_hs = S_AXI_ARVALID_I & arready_r;
	wire logic r_hs  = rvalid_r & S_AXI_RREADY_I;

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	// One read in flight; address is not taken again until data leaves
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= {DATA_W{1'b0}};
		end
		else if (ar_hs)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_r   <= rd_mux;
		end
		else if (r_hs)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	wire logic aw_hs  = S_AXI_AWVALID_I & awready_r;
	wire logic w_hs   = S_AXI_WVALID_I & wready_r;
	wire logic wr_go  = (wr_state_r == WR_IDLE) & aw_got_r & w_got_r;
	wire logic b_hs   = bvalid_r & S_AXI_BREADY_I;
	wire logic wr_lo  = wstrb_r[0];

	wire logic wr_page   = (awaddr_r == byte_addr(IDX_LINK_PAGE));
	wire logic wr_thresh = (awaddr_r == byte_addr(IDX_THRESH));
	wire logic wr_ctrl   = (awaddr_r == byte_addr(IDX_CTRL));
	wire logic wr_istat  = (awaddr_r == byte_addr(IDX_IRQ_STAT));
	wire logic wr_imask  = (awaddr_r == byte_addr(IDX_IRQ_MASK));
	wire logic wr_ro     = (awaddr_r == byte_addr(IDX_DESKEW)) | (awaddr_r == byte_addr(IDX_DISP))
	                     | (awaddr_r == byte_addr(IDX_CODE));
	wire logic wr_hit    = wr_page | wr_thresh | wr_ctrl | wr_istat | wr_imask | wr_ro;
	wire logic wr_do     = wr_go & wr_lo;

	// Address and data are held independently so either may come first
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			aw_got_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			awready_r <= 1'b1;
		end
		else if (aw_hs)
		begin
			aw_got_r  <= 1'b1;
			awaddr_r  <= S_AXI_AWADDR_I;
			awready_r <= 1'b0;
		end
		else if (wr_go)
			aw_got_r <= 1'b0;
		else if (b_hs)
			awready_r <= 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			w_got_r  <= 1'b0;
			wdata_r  <= {DATA_W{1'b0}};
			wstrb_r  <= 4'h0;
			wready_r <= 1'b1;
		end
		else if (w_hs)
		begin
			w_got_r  <= 1'b1;
			wdata_r  <= S_AXI_WDATA_I;
			wstrb_r  <= S_AXI_WSTRB_I;
			wready_r <= 1'b0;
		end
		else if (wr_go)
			w_got_r <= 1'b0;
		else if (b_hs)
			wready_r <= 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			wr_state_r <= WR_IDLE;
			bvalid_r   <= 1'b0;
			bresp_r    <= RESP_OKAY;
		end
		else
		begin
			case (wr_state_r)
				WR_IDLE:
				begin
					if (wr_go)
					begin
						bvalid_r   <= 1'b1;
						bresp_r    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
						wr_state_r <= WR_RESP;
					end
				end
				WR_RESP:
				begin
					if (b_hs)
					begin
						bvalid_r   <= 1'b0;
						wr_state_r <= WR_IDLE;
					end
				end
				default:
				begin
					bvalid_r   <= 1'b0;
					wr_state_r <= WR_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			page_r     <= PAGE_RST;
			thresh_r   <= THRESH_RST;
			irq_mask_r <= IRQ_RST;
			cnt_clr_r  <= 1'b0;
		end
		else
		begin
			if (wr_do & wr_page)
				page_r <= wdata_r[PAGE_W-1:0];
			if (wr_do & wr_thresh)
				thresh_r <= wdata_r[CNT_W-1:0];
			if (wr_do & wr_imask)
				irq_mask_r <= wdata_r[IRQ_W-1:0];
			// Clear is a single pulse; the bit always reads back zero
			cnt_clr_r <= wr_do & wr_ctrl & wdata_r[CTRL_CLR_BIT];
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Events are edges over every link, not only the paged one
	wire logic ev_disp = |(disp_all & ~disp_prev_r);
	wire logic ev_code = |(code_all & ~code_prev_r);
	wire logic ev_dsk  = |(dsk_prev_r & ~dsk_all);

	wire logic [IRQ_W-1:0] irq_ev  = {ev_dsk, ev_code, ev_disp};
	wire logic [IRQ_W-1:0] irq_clr = (wr_do & wr_istat) ? wdata_r[IRQ_W-1:0] : IRQ_RST;

	// A new event beats a clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			irq_stat_r  <= IRQ_RST;
			irq_r       <= 1'b0;
			disp_prev_r <= '0;
			code_prev_r <= '0;
			dsk_prev_r  <= '0;
		end
		else
		begin
			irq_stat_r  <= irq_stat_nxt;
			irq_r       <= |(irq_stat_nxt & irq_mask_r);
			disp_prev_r <= disp_all;
			code_prev_r <= code_all;
			dsk_prev_r  <= dsk_all;
		end
	end

endmodule : slec_status_bank

// ==== verification/slec_link_model.sv ====
// Transmitter side model that drives the per-lane event inputs
`timescale 1ns/1ps
module slec_link_model
	import slec_pkg::*;
(
	input  wire logic                           clk_i,
	input  wire logic                           rstn_i,
	input  wire logic                           fire_i,
	input  wire slec_lane_evt_t [NUM_LINKS-1:0] cmd_i,
	output slec_lane_evt_t      [NUM_LINKS-1:0] evt_o
);
	// Errors are one-cycle pulses, so a burst of n cycles is n counted errors
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			evt_o <= '0;
		else
			for (int k = 0; k < NUM_LINKS; k++)
			begin
				evt_o[k].deskew_ok <= cmd_i[k].deskew_ok;
				evt_o[k].disp_err  <= fire_i ? cmd_i[k].disp_err : 8'h00;
				evt_o[k].code_err  <= fire_i ? cmd_i[k].code_err : 8'h00;
			end
	end
endmodule : slec_link_model

// ==== verification/slec_status_bank_sva.sv ====
// Port checker for the lane error status bank
`timescale 1ns/1ps
module slec_status_bank_sva
	import slec_pkg::*;
(
	input wire logic                           SYS_CLK_I,
	input wire logic                           RESETN_I,
	input wire slec_lane_evt_t [NUM_LINKS-1:0] LANE_EVT_I,
	input wire logic                           S_AXI_AWVALID_I,
	input wire logic                           S_AXI_AWREADY_O,
	input wire logic                           S_AXI_WVALID_I,
	input wire logic                           S_AXI_WREADY_O,
	input wire logic [1:0]                     S_AXI_BRESP_O,
	input wire logic                           S_AXI_BVALID_O,
	input wire logic                           S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0]              S_AXI_ARADDR_I,
	input wire logic                           S_AXI_ARVALID_I,
	input wire logic                           S_AXI_ARREADY_O,
	input wire logic [DATA_W-1:0]              S_AXI_RDATA_O,
	input wire logic [1:0]                     S_AXI_RRESP_O,
	input wire logic                           S_AXI_RVALID_O,
	input wire logic                           S_AXI_RREADY_I
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence s_wr_take; S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O; endsequence
	sequence s_b_wait; !S_AXI_AWREADY_O && !S_AXI_WREADY_O ##1 S_AXI_BVALID_O; endsequence
	sequence s_rd_take; S_AXI_ARVALID_I && S_AXI_ARREADY_O; endsequence
	property p_wr_answer; s_wr_take |=> s_b_wait; endproperty
	property p_wr_refuse; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
	property p_b_stand; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
	property p_rd_answer; s_rd_take |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O; endproperty
	property p_r_stand;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O);
	endproperty
	property p_rd_upper; S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h000000; endproperty
	property p_unmapped;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I < 16'h0c00
			|=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == 32'h00000000;
	endproperty
	// Both links equal and steady, so the page choice cannot matter
	property p_deskew_read;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 16'h11b0
			&& $stable(LANE_EVT_I[0].deskew_ok) && $stable(LANE_EVT_I[1].deskew_ok)
			&& LANE_EVT_I[0].deskew_ok == LANE_EVT_I[1].deskew_ok
			|=> S_AXI_RDATA_O[7:0] == $past(LANE_EVT_I[0].deskew_ok, 2);
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_wr_refuse: assert property (p_wr_refuse) else $error("write ready during response");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	a_deskew_read: assert property (p_deskew_read) else $error("deskew flags wrong");
endmodule : slec_status_bank_sva

bind slec_status_bank slec_status_bank_sva slec_status_bank_sva_inst (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
	.LANE_EVT_I(LANE_EVT_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));

// ==== verification/test_slec_status_bank.sv ====
// Self-checking bench for the lane error status bank
`timescale 1ns/1ps
module test_slec_status_bank;
	import slec_pkg::*;
	logic                           clk, rstn, fire, awv, wv, br, arv, rr, awr, wr_r, bv, arr, rv, irq;
	slec_lane_evt_t [NUM_LINKS-1:0] cmd, evt;
	logic [ADDR_W-1:0]              awaddr, araddr;
	logic [DATA_W-1:0]              wdata, rdata;
	logic [3:0]                     wstrb;
	logic [1:0]                     bresp, rresp;
	logic [33:0]                    rq[$];
	logic [1:0]                     bq[$];
	logic [3:0]                     wsel;
	logic [7:0]                     th, m, m2, d0, d1;
	int                             fail_count, n_tests;

	slec_link_model slec_link_model_inst (.clk_i(clk), .rstn_i(rstn), .fire_i(fire), .cmd_i(cmd), .evt_o(evt));
	slec_status_bank slec_status_bank_inst (.SYS_CLK_I(clk), .RESETN_I(rstn), .LANE_EVT_I(evt),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rr), .IRQ_O(irq));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: read got %h expected %h", $time, got, exp);
		end
	endtask : cmp_rd

	task automatic cmp_wr(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: write response got %h expected %h", $time, got, exp);
		end
	endtask : cmp_wr

	// Looked at on the falling edge, where the registered level has settled
	task automatic cmp_irq(input logic exp);
		@(negedge clk);
		n_tests++;
		if (irq !== exp)
		begin
			fail_count++;
			$display("ERROR %0t: interrupt got %b expected %b", $time, irq, exp);
		end
	endtask : cmp_irq

	task automatic hang;
		fail_count++;
		$display("ERROR %0t: bus answer missing", $time);
		test_done();
	endtask : hang

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [1:0] resp);
		int i;
		@(posedge clk);
		bq.push_back(resp);
		awaddr <= {2'h0, idx, 2'h0};
		wdata  <= d;
		wstrb  <= wsel;
		awv    <= 1'b1;
		wv     <= 1'b1;
		br     <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
			if (bv) break;
		end
		br <= 1'b0;
		if (i == 40) hang();
	endtask : wr

	task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [1:0] resp);
		int i;
		@(posedge clk);
		rq.push_back({resp, d});
		araddr <= {2'h0, idx, 2'h0};
		arv    <= 1'b1;
		rr     <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rr <= 1'b0;
		if (i == 40) hang();
	endtask : rd

	task automatic burst(input int ln, input logic [7:0] dm, input logic [7:0] cm, input int n);
		@(posedge clk);
		cmd[ln].disp_err <= dm;
		cmd[ln].code_err <= cm;
		fire <= 1'b1;
		repeat (n) @(posedge clk);
		fire <= 1'b0;
		// Drop the pattern so a later burst on another link does not repeat it
		cmd[ln].disp_err <= 8'h00;
		cmd[ln].code_err <= 8'h00;
		repeat (3) @(posedge clk);
	endtask : burst

	// Results are judged where they appear, against the oldest note
	always @(posedge clk)
	begin
		if (rv && rr) cmp_rd({rresp, rdata}, rq.pop_front());
		if (bv && br) cmp_wr(bresp, bq.pop_front());
	end

	initial
	begin
		{rstn, fire, awv, wv, br, arv, rr} = '0;
		{cmd, awaddr, araddr, wdata, wstrb} = '0;
		fail_count = 0;
		n_tests = 0;
		wsel = 4'hf;
		void'($urandom(32'hbb7c9933));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(IDX_DESKEW, 0, RESP_OKAY);
		rd(IDX_DISP, 0, RESP_OKAY);
		rd(IDX_CODE, 0, RESP_OKAY);
		rd(IDX_LINK_PAGE, 0, RESP_OKAY);
		rd(IDX_THRESH, 32'h000000ff, RESP_OKAY);
		rd(12'h000, 0, RESP_SLVERR);
		wr(12'h000, 1, RESP_SLVERR);
		wr(IDX_DISP, 32'h000000ff, RESP_OKAY);
		rd(IDX_DISP, 0, RESP_OKAY);
		$display("test reset_values done");
		d0 = 8'($urandom) & 8'h7f;
		d1 = d0 | 8'($urandom) | 8'h80;
		cmd[0].deskew_ok <= d0;
		cmd[1].deskew_ok <= d0;
		repeat (3) @(posedge clk);
		rd(IDX_DESKEW, {24'h0, d0}, RESP_OKAY);
		cmd[1].deskew_ok <= d1;
		wr(IDX_LINK_PAGE, 1, RESP_OKAY);
		rd(IDX_DESKEW, {24'h0, d1}, RESP_OKAY);
		$display("test deskew_paged done");
		th = 8'd2 + 8'($urandom % 5);
		m = 8'($urandom) | 8'h01;
		m2 = 8'($urandom) | 8'h80;
		wr(IDX_THRESH, {24'h0, th}, RESP_OKAY);
		burst(0, m, 8'h00, th - 1);
		burst(1, 8'h00, m2, th);
		rd(IDX_DISP, 0, RESP_OKAY);
		rd(IDX_CODE, {24'h0, m2}, RESP_OKAY);
		wr(IDX_LINK_PAGE, 0, RESP_OKAY);
		rd(IDX_DISP, 0, RESP_OKAY);
		burst(0, m, 8'h00, 1);
		rd(IDX_DISP, {24'h0, m}, RESP_OKAY);
		rd(IDX_CODE, 0, RESP_OKAY);
		$display("test thresholds done");
		rd(IDX_IRQ_STAT, 3, RESP_OKAY);
		cmp_irq(1'b0);
		wr(IDX_IRQ_MASK, 1, RESP_OKAY);
		repeat (2) @(posedge clk);
		cmp_irq(1'b1);
		wr(IDX_IRQ_STAT, 1, RESP_OKAY);
		repeat (2) @(posedge clk);
		cmp_irq(1'b0);
		rd(IDX_IRQ_STAT, 2, RESP_OKAY);
		$display("test interrupts done");
		wr(IDX_CTRL, 1, RESP_OKAY);
		rd(IDX_CTRL, 0, RESP_OKAY);
		repeat (2) @(posedge clk);
		rd(IDX_DISP, 0, RESP_OKAY);
		wsel = 4'he;
		wr(IDX_THRESH, 0, RESP_OKAY);
		wsel = 4'hf;
		rd(IDX_THRESH, {24'h0, th}, RESP_OKAY);
		wr(IDX_THRESH, 0, RESP_OKAY);
		rd(IDX_DISP, 32'h000000ff, RESP_OKAY);
		rd(IDX_CODE, 32'h000000ff, RESP_OKAY);
		repeat (4) @(posedge clk);
		$display("test counter_clear done");
		test_done();
	end
endmodule : test_slec_status_bank
